/* File: logic/freq_ctrl_pkg.sv */
// constants, types and carriers for the frequency-control core
`default_nettype none
package freq_ctrl_pkg;

    // ========================================================
    // attribute offsets
    localparam int             ATTR_ADDR_W      = 12;
    localparam logic [11:0]    ATTR_CL_ON_OFS   = 12'hBCE;
    localparam logic [11:0]    ATTR_CL_KD_OFS   = 12'hBCF;
    localparam logic [11:0]    ATTR_CL_KI_OFS   = 12'hBD0;
    localparam logic [11:0]    ATTR_CL_KP_OFS   = 12'hBD1;
    localparam logic [11:0]    ATTR_ST_ON_OFS   = 12'hBD2;
    localparam logic [11:0]    ATTR_ST_BW_OFS   = 12'hBD3;
    localparam logic [11:0]    ATTR_ST_VG_OFS   = 12'hBD4;
    localparam logic [11:0]    ATTR_ST_AG_OFS   = 12'hBD5;

    // ========================================================
    // gain table layout
    localparam int             GAIN_N = 6;
    localparam int             G_KD   = 0;
    localparam int             G_KI   = 1;
    localparam int             G_KP   = 2;
    localparam int             G_BW   = 3;
    localparam int             G_VG   = 4;
    localparam int             G_AG   = 5;
    localparam logic [GAIN_N-1:0][11:0] GAIN_OFS = {ATTR_ST_AG_OFS, ATTR_ST_VG_OFS,
                                                    ATTR_ST_BW_OFS, ATTR_CL_KP_OFS,
                                                    ATTR_CL_KI_OFS, ATTR_CL_KD_OFS};

    // ========================================================
    // reset values
    localparam logic [7:0]     FLAG_OFF   = 8'h00;
    localparam logic [7:0]     FLAG_ON    = 8'h01;
    localparam logic [31:0]    GAIN_RESET = 32'h0000_0000;

    // ========================================================
    // timing
    localparam longint         CLK_PERIOD_NS  = 40;
    localparam longint         CTRL_PERIOD_NS = 100000;
    localparam logic [11:0]    CTRL_TICK_CYC  = 12'(CTRL_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [31:0]    TS_Q32         = 32'((64'd4294967296 * CTRL_PERIOD_NS)
                                                    / 64'd1000000000);
    localparam logic [31:0]    CTRL_RATE_HZ   = 32'(64'd1000000000 / CTRL_PERIOD_NS);
    localparam logic [31:0]    ANGLE_TO_HZ    = 32'((CTRL_RATE_HZ * 1000) / 6283);
    localparam int             DIV_STEPS      = 48;

    // ========================================================
    // types
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DIV  = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } attr_req_t;

    typedef struct packed {
        logic signed [31:0] rated_freq;
        logic signed [31:0] rated_volt;
        logic signed [31:0] run_boost;
        logic signed [31:0] stator_res;
        logic signed [31:0] slip_gain;
    } motor_cfg_t;

    typedef struct packed {
        logic signed [31:0] motor_therm;
        logic signed [31:0] inv_therm;
        logic signed [31:0] motor_peak;
        logic signed [31:0] drive_peak;
        logic signed [31:0] user_cap;
    } limits_t;

endpackage
`default_nettype wire

/* File: logic/ratio_divider.sv */
// sequential restoring divider for the frequency ratio
`timescale 1ns/1ps
`default_nettype none
module ratio_divider
    import freq_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // request
    input  wire logic        start_i,
    input  wire logic [47:0] dividend_i,
    input  wire logic [31:0] divisor_i,
    // answer
    output logic             done_o,
    output logic [31:0]      quotient_o
);
    typedef struct packed {
        logic        busy;
        logic        done;
        logic [5:0]  cnt;
        logic [47:0] quo;
        logic [32:0] rem;
        logic [31:0] dvs;
        logic [31:0] res;
    } div_state_t;

    div_state_t r_reg;
    div_state_t r_next;

    // ========================================================
    // iteration
    always_comb begin
        logic [32:0] trial;
        trial       = 33'h0_0000_0000;
        r_next      = r_reg;
        r_next.done = 1'b0;
        if (start_i && !r_reg.busy) begin
            r_next.busy = 1'b1;
            r_next.cnt  = 6'(DIV_STEPS);
            r_next.quo  = dividend_i;
            r_next.rem  = 33'h0_0000_0000;
            r_next.dvs  = divisor_i;
        end else if (r_reg.busy) begin
            trial      = {r_reg.rem[31:0], r_reg.quo[47]};
            r_next.quo = {r_reg.quo[46:0], 1'b0};
            if (trial >= {1'b0, r_reg.dvs}) begin
                r_next.rem    = trial - {1'b0, r_reg.dvs};
                r_next.quo[0] = 1'b1;
            end else begin
                r_next.rem = trial;
            end
            r_next.cnt = r_reg.cnt - 6'h01;
            if (r_reg.cnt == 6'h01) begin
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
                if (r_reg.dvs == 32'h0000_0000 || r_next.quo[47:31] != 17'h0_0000) begin
                    r_next.res = 32'h7FFF_FFFF;
                end else begin
                    r_next.res = r_next.quo[31:0];
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign done_o     = r_reg.done;
    assign quotient_o = r_reg.res;

endmodule // ratio_divider
`default_nettype wire

/* File: logic/induction_freq_control_limits.sv */
// frequency-control core: fan/pump law, sensorless vector, current limiter, stabiliser
`timescale 1ns/1ps
`default_nettype none
module induction_freq_control_limits
    import freq_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic               CLK_SYS_I,
    input  wire logic               RST_I,
    // attribute messaging
    input  wire attr_req_t          ATTR_REQ_I,
    output logic [31:0]             ATTR_RDATA_O,
    output logic                    ATTR_ACK_O,
    output logic                    ATTR_ERR_O,
    // axis operation
    input  wire logic               FREQ_CTRL_I,
    input  wire logic               SENSORLESS_MODE_I,
    input  wire logic               DIRECT_DRIVE_START_I,
    input  wire logic signed [31:0] VEL_REF_I,
    input  wire logic signed [31:0] PHASE_CURRENT_I,
    input  wire motor_cfg_t         MOTOR_CFG_I,
    input  wire limits_t            CURRENT_LIMITS_I,
    // drive commands and status
    output logic signed [31:0]      DRIVE_OUTPUT_FREQ_O,
    output logic signed [31:0]      DRIVE_OUTPUT_VOLTS_O,
    output logic signed [31:0]      LIMITED_VEL_REF_O,
    output logic signed [31:0]      EFFECTIVE_CURRENT_CEILING_O,
    output logic                    LIMITER_ACTIVE_O,
    output logic                    STABILISER_ACTIVE_O,
    output logic                    OUT_VALID_O
);

    typedef struct packed {
        seq_state_t                     st;
        logic [11:0]                    tick_cnt;
        logic                           div_start;
        logic [7:0]                     cl_on;
        logic [7:0]                     st_on;
        logic [GAIN_N-1:0][31:0]        gain;
        logic [31:0]                    rdata;
        logic                           ack;
        logic                           err;
        logic signed [31:0]             ceiling;
        logic signed [31:0]             i_filt;
        logic signed [31:0]             integ;
        logic signed [31:0]             err_prev;
        logic signed [31:0]             f_lim;
        logic signed [31:0]             v_out;
        logic signed [31:0]             f_out;
        logic                           lim_act;
        logic                           stab_act;
        logic                           out_valid;
    } core_state_t;

    core_state_t                    r_reg;
    core_state_t                    r_next;
    logic signed [GAIN_N-1:0][31:0] gain_fix;
    logic                           div_done;
    logic [31:0]                    div_quo;
    logic [31:0]                    f_lim_abs;

    // ========================================================
    // fixed-point helpers (Q16.16)
    function automatic logic signed [31:0] fmul(input logic signed [31:0] a,
                                                input logic signed [31:0] b);
        logic signed [63:0] p;
        p = a * b;
        return p[47:16];
    endfunction

    function automatic logic signed [31:0] tmul(input logic signed [31:0] x);
        logic signed [63:0] p;
        p = x * $signed({1'b0, TS_Q32});
        return p[63:32];
    endfunction

    function automatic logic signed [31:0] sabs(input logic signed [31:0] x);
        return (x < 0) ? -x : x;
    endfunction

    function automatic logic signed [31:0] smin(input logic signed [31:0] a,
                                                input logic signed [31:0] b);
        return (a < b) ? a : b;
    endfunction

    function automatic logic signed [31:0] float_to_q16(input logic [31:0] f);
        logic [7:0]  e;
        logic [31:0] m;
        logic [31:0] mag;
        e = f[30:23];
        m = {9'h001, f[22:0]};
        if (e == 8'h00) begin
            mag = 32'h0000_0000;
        end else if (e > 8'd141) begin
            mag = 32'h7FFF_FFFF;
        end else if (e >= 8'd134) begin
            mag = m << (e - 8'd134);
        end else if ((8'd134 - e) >= 8'd24) begin
            mag = 32'h0000_0000;
        end else begin
            mag = m >> (8'd134 - e);
        end
        return f[31] ? -$signed(mag) : $signed(mag);
    endfunction

    // ========================================================
    // float gains to fixed point
    genvar gi;
    generate
        for (gi = 0; gi < GAIN_N; gi++) begin : g_conv
            assign gain_fix[gi] = float_to_q16(r_reg.gain[gi]);
        end
    endgenerate

    // ========================================================
    // frequency ratio divider
    assign f_lim_abs = sabs(r_reg.f_lim);

    ratio_divider u_ratio_divider (
        .clk_i      (CLK_SYS_I),
        .rst_i      (RST_I),
        .start_i    (r_reg.div_start),
        .dividend_i ({f_lim_abs, 16'h0000}),
        .divisor_i  (MOTOR_CFG_I.rated_freq),
        .done_o     (div_done),
        .quotient_o (div_quo)
    );

    // ========================================================
    // next state
    always_comb begin
        logic signed [31:0] err;
        logic signed [31:0] integ_n;
        logic signed [31:0] trim;
        logic signed [31:0] f_cand;
        logic signed [31:0] alpha;
        logic signed [31:0] ratio;
        logic signed [31:0] vspan;
        logic signed [31:0] volts;
        logic signed [31:0] freq;
        logic signed [31:0] boost;
        logic signed [31:0] slip;
        logic signed [31:0] hp;
        logic               lim_on;
        logic               stab_on;
        err         = 32'sh0;
        integ_n     = 32'sh0;
        trim        = 32'sh0;
        f_cand      = 32'sh0;
        alpha       = 32'sh0;
        ratio       = 32'sh0;
        vspan       = 32'sh0;
        volts       = 32'sh0;
        freq        = 32'sh0;
        boost       = 32'sh0;
        slip        = 32'sh0;
        hp          = 32'sh0;
        lim_on      = 1'b0;
        stab_on     = 1'b0;
        r_next      = r_reg;
        r_next.ack  = 1'b0;
        r_next.err  = 1'b0;
        r_next.div_start = 1'b0;
        r_next.out_valid = 1'b0;

        // ========================================================
        // attribute access
        if (ATTR_REQ_I.wr || ATTR_REQ_I.rd) begin
            r_next.ack   = 1'b1;
            r_next.err   = 1'b1;
            r_next.rdata = 32'h0000_0000;
            if (ATTR_REQ_I.addr == ATTR_CL_ON_OFS) begin
                r_next.err   = 1'b0;
                r_next.rdata = {24'h00_0000, r_reg.cl_on};
                if (ATTR_REQ_I.wr) begin
                    r_next.cl_on = ATTR_REQ_I.wdata[7:0];
                end
            end
            if (ATTR_REQ_I.addr == ATTR_ST_ON_OFS) begin
                r_next.err   = 1'b0;
                r_next.rdata = {24'h00_0000, r_reg.st_on};
                if (ATTR_REQ_I.wr) begin
                    r_next.st_on = ATTR_REQ_I.wdata[7:0];
                end
            end
            for (int k = 0; k < GAIN_N; k++) begin
                if (ATTR_REQ_I.addr == GAIN_OFS[k]) begin
                    r_next.err   = 1'b0;
                    r_next.rdata = r_reg.gain[k];
                    if (ATTR_REQ_I.wr) begin
                        r_next.gain[k] = ATTR_REQ_I.wdata;
                    end
                end
            end
        end

        // ========================================================
        // effective ceiling, user cap included
        r_next.ceiling = smin(smin(smin(CURRENT_LIMITS_I.motor_therm,
                                        CURRENT_LIMITS_I.inv_therm),
                                   smin(CURRENT_LIMITS_I.motor_peak,
                                        CURRENT_LIMITS_I.drive_peak)),
                              CURRENT_LIMITS_I.user_cap);

        // ========================================================
        // control tick
        if (r_reg.tick_cnt == 12'h000) begin
            r_next.tick_cnt = CTRL_TICK_CYC - 12'h001;
        end else begin
            r_next.tick_cnt = r_reg.tick_cnt - 12'h001;
        end

        unique case (r_reg.st)
            ST_IDLE: begin
                if (r_reg.tick_cnt == 12'h000) begin
                    // current feedback low-pass
                    alpha = tmul(gain_fix[G_BW]);
                    r_next.i_filt = r_reg.i_filt
                                  + fmul(alpha, PHASE_CURRENT_I - r_reg.i_filt);
                    // ====================================================
                    // limiter regulator
                    lim_on = (r_reg.cl_on == FLAG_ON) && FREQ_CTRL_I
                           && DIRECT_DRIVE_START_I;
                    err    = PHASE_CURRENT_I - r_reg.ceiling;
                    f_cand = VEL_REF_I;
                    if (lim_on) begin
                        integ_n = r_reg.integ + tmul(fmul(gain_fix[G_KI], err));
                        if (integ_n < 0) begin
                            integ_n = 32'sh0;
                        end
                        trim = fmul(gain_fix[G_KP], err) + integ_n
                             + fmul(gain_fix[G_KD], err - r_reg.err_prev)
                               * $signed(CTRL_RATE_HZ);
                        if (trim < 0) begin
                            trim = 32'sh0;
                        end
                        if (trim > sabs(VEL_REF_I)) begin
                            trim = sabs(VEL_REF_I);
                        end
                        f_cand = (VEL_REF_I < 0) ? VEL_REF_I + trim : VEL_REF_I - trim;
                        if (err > 0 && sabs(f_cand) > sabs(r_reg.f_lim)) begin
                            f_cand = r_reg.f_lim;
                        end
                    end
                    r_next.integ     = integ_n;
                    r_next.err_prev  = lim_on ? err : 32'sh0;
                    r_next.f_lim     = f_cand;
                    r_next.lim_act   = lim_on;
                    r_next.div_start = 1'b1;
                    r_next.st        = ST_DIV;
                end
            end
            ST_DIV: begin
                if (div_done) begin
                    ratio = $signed(div_quo);
                    vspan = MOTOR_CFG_I.rated_volt - MOTOR_CFG_I.run_boost;
                    freq  = r_reg.f_lim;
                    if (SENSORLESS_MODE_I) begin
                        boost = fmul(MOTOR_CFG_I.stator_res, r_reg.i_filt);
                        slip  = fmul(MOTOR_CFG_I.slip_gain,
                                     fmul(r_reg.i_filt, r_reg.v_out));
                        volts = fmul(ratio, vspan) + MOTOR_CFG_I.run_boost + boost;
                        freq  = (r_reg.f_lim < 0) ? r_reg.f_lim - slip
                                                  : r_reg.f_lim + slip;
                    end else begin
                        volts = fmul(fmul(ratio, ratio), vspan)
                              + MOTOR_CFG_I.run_boost;
                    end
                    stab_on = (r_reg.st_on == FLAG_ON) && FREQ_CTRL_I;
                    if (stab_on) begin
                        hp    = PHASE_CURRENT_I - r_reg.i_filt;
                        freq  = freq - fmul(gain_fix[G_AG], hp)
                                     * $signed(ANGLE_TO_HZ);
                        volts = volts - fmul(gain_fix[G_VG], hp);
                    end
                    r_next.f_out     = freq;
                    r_next.v_out     = volts;
                    r_next.stab_act  = stab_on;
                    r_next.out_valid = 1'b1;
                    r_next.st        = ST_IDLE;
                end
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase
    end

    // ========================================================
    // state register
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            r_reg          <= '0;
            r_reg.st       <= ST_IDLE;
            r_reg.tick_cnt <= CTRL_TICK_CYC - 12'h001;
            r_reg.cl_on    <= FLAG_OFF;
            r_reg.st_on    <= FLAG_OFF;
            r_reg.gain     <= {GAIN_N{GAIN_RESET}};
        end else begin
            r_reg <= r_next;
        end
    end

    // ========================================================
    // outputs
    assign ATTR_RDATA_O                = r_reg.rdata;
    assign ATTR_ACK_O                  = r_reg.ack;
    assign ATTR_ERR_O                  = r_reg.err;
    assign DRIVE_OUTPUT_FREQ_O         = r_reg.f_out;
    assign DRIVE_OUTPUT_VOLTS_O        = r_reg.v_out;
    assign LIMITED_VEL_REF_O           = r_reg.f_lim;
    assign EFFECTIVE_CURRENT_CEILING_O = r_reg.ceiling;
    assign LIMITER_ACTIVE_O            = r_reg.lim_act;
    assign STABILISER_ACTIVE_O         = r_reg.stab_act;
    assign OUT_VALID_O                 = r_reg.out_valid;

endmodule // induction_freq_control_limits
`default_nettype wire

/* File: testbench/freq_ctrl_asserts.sv */
// concurrent checks on the frequency-control core ports
`timescale 1ns/1ps
`default_nettype none
module freq_ctrl_asserts
    import freq_ctrl_pkg::*;
(
    // clock, reset and attribute port
    input  wire logic               CLK_SYS_I,
    input  wire logic               RST_I,
    input  wire attr_req_t          ATTR_REQ_I,
    input  wire logic [31:0]        ATTR_RDATA_O,
    input  wire logic               ATTR_ACK_O,
    input  wire logic               ATTR_ERR_O,
    // axis side
    input  wire logic               FREQ_CTRL_I,
    input  wire logic               DIRECT_DRIVE_START_I,
    input  wire limits_t            CURRENT_LIMITS_I,
    input  wire logic signed [31:0] DRIVE_OUTPUT_FREQ_O,
    input  wire logic signed [31:0] DRIVE_OUTPUT_VOLTS_O,
    input  wire logic signed [31:0] EFFECTIVE_CURRENT_CEILING_O,
    input  wire logic               LIMITER_ACTIVE_O,
    input  wire logic               STABILISER_ACTIVE_O,
    input  wire logic               OUT_VALID_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    function automatic logic signed [31:0] lo(input logic signed [31:0] a,
                                              input logic signed [31:0] b);
        return (a < b) ? a : b;
    endfunction
    limits_t            c;
    logic signed [31:0] mn;
    assign c  = CURRENT_LIMITS_I;
    assign mn = lo(lo(lo(c.motor_therm, c.inv_therm), lo(c.motor_peak, c.drive_peak)), c.user_cap);
    sequence req_s; ATTR_REQ_I.wr || ATTR_REQ_I.rd; endsequence
    sequence ans_s; ##1 ATTR_ACK_O; endsequence
    ack_after_req_a: assert property (req_s |-> ans_s) else $error("no ack");
    no_stray_ack_a: assert property (!(ATTR_REQ_I.wr || ATTR_REQ_I.rd) |=> !ATTR_ACK_O)
        else $error("stray ack");
    err_zero_data_a: assert property (ATTR_ERR_O |->
        ATTR_ACK_O && ATTR_RDATA_O == 32'h0) else $error("bad refusal");
    ceiling_min_a: assert property (!$past(RST_I) |->
        EFFECTIVE_CURRENT_CEILING_O == $past(mn)) else $error("ceiling not min");
    ceiling_cap_a: assert property (!$past(RST_I) |->
        EFFECTIVE_CURRENT_CEILING_O <= $past(c.user_cap)) else $error("ceiling above cap");
    valid_spacing_a: assert property (OUT_VALID_O |=> !OUT_VALID_O [*8])
        else $error("valid too close");
    cmd_on_valid_a: assert property ($changed(DRIVE_OUTPUT_FREQ_O) ||
        $changed(DRIVE_OUTPUT_VOLTS_O) |-> OUT_VALID_O) else $error("command moved");
    limiter_gate_a: assert property ($rose(LIMITER_ACTIVE_O) |->
        $past(FREQ_CTRL_I && DIRECT_DRIVE_START_I)) else $error("limiter ungated");
    stab_update_a: assert property ($changed(STABILISER_ACTIVE_O) |-> OUT_VALID_O)
        else $error("stabiliser flag moved");
endmodule // freq_ctrl_asserts
`default_nettype wire

/* File: testbench/mc_model.sv */
// motion controller model issuing attribute messages
`timescale 1ns/1ps
`default_nettype none
module mc_model
    import freq_ctrl_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic        ack_i,
    input  wire logic        err_i,
    output attr_req_t        req_o
);
    initial req_o = '0;
    // one access; released fields show inverted values
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk_i);
        req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(posedge clk_i);
        q = ack_i ? rdata_i : ~rdata_i;
        e = err_i;
    endtask
endmodule // mc_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the frequency-control core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import freq_ctrl_pkg::*;
    logic CLK_SYS_I, RST_I, fc, sens, dds, ack, err, o_valid, lim_act, stab_act;
    logic signed [31:0] vel_ref, i_ph, o_freq, o_volts, lim_ref, ceil;
    logic [31:0] rdata;
    attr_req_t req;
    motor_cfg_t mcfg;
    limits_t lims;
    int checks = 0;
    int miscompares = 0;
    induction_freq_control_limits u_induction_freq_control_limits (.CLK_SYS_I, .RST_I,
        .ATTR_REQ_I(req), .ATTR_RDATA_O(rdata), .ATTR_ACK_O(ack), .ATTR_ERR_O(err),
        .FREQ_CTRL_I(fc), .SENSORLESS_MODE_I(sens), .DIRECT_DRIVE_START_I(dds),
        .VEL_REF_I(vel_ref), .PHASE_CURRENT_I(i_ph), .MOTOR_CFG_I(mcfg),
        .CURRENT_LIMITS_I(lims), .DRIVE_OUTPUT_FREQ_O(o_freq), .DRIVE_OUTPUT_VOLTS_O(o_volts),
        .LIMITED_VEL_REF_O(lim_ref), .EFFECTIVE_CURRENT_CEILING_O(ceil),
        .LIMITER_ACTIVE_O(lim_act), .STABILISER_ACTIVE_O(stab_act), .OUT_VALID_O(o_valid));
    mc_model u_mc_model (.clk_i(CLK_SYS_I), .rdata_i(rdata), .ack_i(ack), .err_i(err),
        .req_o(req));
    initial begin
        CLK_SYS_I = 1'b0;
        forever #20 CLK_SYS_I = ~CLK_SYS_I;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic x);
        logic [31:0] q;
        logic        r;
        u_mc_model.acc(1'b0, a, 32'h0, q, r);
        chk("rdata", q, e);
        chk("err", {31'h0, r}, {31'h0, x});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        r;
        u_mc_model.acc(1'b1, a, d, q, r);
    endtask
    task automatic tick(input int n);
        int k;
        repeat (n) begin
            k = 0;
            @(posedge CLK_SYS_I);
            while (o_valid !== 1'b1 && k < 2600) begin
                @(posedge CLK_SYS_I);
                k++;
            end
            chk("out valid", {31'h0, o_valid}, 32'h1);
        end
    endtask
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================
    // attribute table
    task automatic t_regs;
        rd(ATTR_CL_ON_OFS, 32'h0, 1'b0);
        rd(ATTR_ST_ON_OFS, 32'h0, 1'b0);
        rd(12'hBD6, 32'h0, 1'b1);
        for (int i = 0; i < GAIN_N; i++) rd(GAIN_OFS[i], GAIN_RESET, 1'b0);
        for (int i = 0; i < GAIN_N; i++) wr(GAIN_OFS[i], 32'h3F80_0000 + i);
        for (int i = 0; i < GAIN_N; i++) rd(GAIN_OFS[i], 32'h3F80_0000 + i, 1'b0);
        wr(ATTR_CL_ON_OFS, 32'h1234_56FF);
        rd(ATTR_CL_ON_OFS, 32'h0000_00FF, 1'b0);
        for (int i = 0; i < GAIN_N; i++) wr(GAIN_OFS[i], GAIN_RESET);
        wr(ATTR_CL_ON_OFS, 32'h0);
    endtask
    // ==========================================
    // ceiling is the least of five limits
    task automatic t_ceil;
        limits_t l;
        for (int i = 0; i < 5; i++) begin
            l = {5{32'h000A_0000}};
            l[i*32 +: 32] = 32'h0003_0000;
            lims <= l;
            repeat (2) @(posedge CLK_SYS_I);
            chk("ceiling", ceil, 32'h0003_0000);
        end
    endtask
    // ==========================================
    // square law with run boost
    task automatic t_fan;
        mcfg <= '{32'h003C_0000, 32'h0190_0000, 32'h000A_0000, 32'h0001_0000, 32'h0001_0000};
        vel_ref <= 32'h001E_0000;
        tick(2);
        chk("fan freq", o_freq, 32'h001E_0000);
        chk("fan volts", o_volts, 32'h006B_8000);
        mcfg.run_boost <= 32'h0014_0000;
        tick(2);
        chk("boost volts", o_volts, 32'h0073_0000);
    endtask
    // ==========================================
    // sensorless slip and boost
    task automatic t_sv;
        wr(ATTR_ST_BW_OFS, 32'h447A_0000);
        sens <= 1'b1;
        i_ph <= 32'h0002_0000;
        tick(2);
        chk("sv boost", {31'h0, o_volts > 32'sh00CD_0000}, 32'h1);
        chk("sv slip", {31'h0, o_freq > 32'sh001E_0000}, 32'h1);
        sens <= 1'b0;
    endtask
    // ==========================================
    // limiter gating and trim
    task automatic t_lim;
        wr(ATTR_CL_ON_OFS, 32'h1);
        wr(ATTR_CL_KP_OFS, 32'h3F80_0000);
        lims <= {{4{32'h000A_0000}}, 32'h0001_0000};
        i_ph <= 32'h0005_0000;
        dds <= 1'b1;
        tick(2);
        chk("limiting", {31'h0, lim_act}, 32'h1);
        chk("trimmed", {31'h0, lim_ref < vel_ref}, 32'h1);
        dds <= 1'b0;
        tick(2);
        chk("no start", {31'h0, lim_act}, 32'h0);
        chk("ref passes", lim_ref, vel_ref);
        wr(ATTR_CL_ON_OFS, 32'h0);
        dds <= 1'b1;
        tick(2);
        chk("flag off", {31'h0, lim_act}, 32'h0);
    endtask
    // ==========================================
    // stabiliser gating
    task automatic t_stab;
        wr(ATTR_CL_ON_OFS, 32'h1);
        wr(ATTR_ST_VG_OFS, 32'h3F80_0000);
        wr(ATTR_ST_AG_OFS, 32'h3F80_0000);
        wr(ATTR_ST_ON_OFS, 32'h1);
        i_ph <= 32'h0008_0000;
        tick(2);
        chk("stab on", {31'h0, stab_act}, 32'h1);
        fc <= 1'b0;
        tick(2);
        chk("stab freq off", {31'h0, stab_act}, 32'h0);
    endtask
    initial begin
        RST_I = 1'b1;
        fc = 1'b1;
        sens = 1'b0;
        dds = 1'b0;
        vel_ref = '0;
        i_ph = '0;
        mcfg = '0;
        lims = {5{32'h000A_0000}};
        repeat (3) @(posedge CLK_SYS_I);
        RST_I <= 1'b0;
        t_regs();
        t_ceil();
        t_fan();
        t_sv();
        t_lim();
        t_stab();
        close_out();
    end
    initial begin
        repeat (90000) @(posedge CLK_SYS_I);
        miscompares++;
        close_out();
    end
endmodule // tb_top
bind induction_freq_control_limits freq_ctrl_asserts u_chk (.CLK_SYS_I, .RST_I, .ATTR_REQ_I,
    .ATTR_RDATA_O, .ATTR_ACK_O, .ATTR_ERR_O, .FREQ_CTRL_I, .DIRECT_DRIVE_START_I,
    .CURRENT_LIMITS_I, .DRIVE_OUTPUT_FREQ_O, .DRIVE_OUTPUT_VOLTS_O,
    .EFFECTIVE_CURRENT_CEILING_O, .LIMITER_ACTIVE_O, .STABILISER_ACTIVE_O, .OUT_VALID_O);
`default_nettype wire
